/* scmrc_mem.sv */
// memory end: shifts stored words out one bit per clock, drives cascade out
// assumes pins come from the link, so each passes two flip-flops first
`timescale 1ns/1ps
`default_nettype none
module scmrc_mem (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // synchronous reset, active low
	scmrc_if.mem lnk, // pins toward the reader
	input wire logic [scmrc_pkg::SCMRC_WORD_BITS-1:0] pol_word, // overflow word
	output logic in_standby, // chip select high
	output logic pgm_mode // programming entry seen
);
	import scmrc_pkg::*;
	typedef struct packed {
		logic [1:0] ce_s;
		logic [1:0] oe_s;
		logic [1:0] vpp_s;
		logic [SCMRC_ADDR_W-1:0] addr;
		logic [SCMRC_BIT_W-1:0] bitc;
		scmrc_rd_e st;
		logic cas_n;
		logic dout;
		logic doe;
		logic pol_hi;
		logic [1:0] vcnt;
		logic vhigh_done;
		logic pgm;
		logic stby;
	} scmrc_mem_s;
	scmrc_mem_s s_reg, s_next;
	logic [SCMRC_WORD_BITS-1:0] rom [0:(1<<SCMRC_ADDR_W)-1];
	logic ce_n, oe_raw, rst_lvl, oe_n, last;
	// contents start blank (all ones) and are not written here; read path only
	initial begin
		for (int i = 0; i < (1<<SCMRC_ADDR_W); i++) rom[i] = '1;
	end
	always_comb begin
		s_next = s_reg;
		ce_n = s_reg.ce_s[1];
		oe_raw = s_reg.oe_s[1];
		// polarity ignored in programming mode
		rst_lvl = s_reg.pgm ? oe_raw : (s_reg.pol_hi ? oe_raw : ~oe_raw); // see (R9)
		// the enable level is simply the non-reset level of the shared pin
		oe_n = rst_lvl;
		last = (s_reg.addr == SCMRC_LAST_ADDR) && (s_reg.bitc == SCMRC_LAST_BIT);
		s_next.ce_s = {s_reg.ce_s[0], lnk.ce_n};
		s_next.oe_s = {s_reg.oe_s[0], lnk.reset_oe};
		s_next.vpp_s = {s_reg.vpp_s[0], lnk.vpp_high};
		// overflow word sampled each cycle; only all-zero selects active low
		s_next.pol_hi = (pol_word != SCMRC_POL_LOW); // see (R9) (R10)
		s_next.stby = ce_n; // see (R5)
		if (rst_lvl) begin
			// counters cleared by reset level, also by system reset fall
			s_next.addr = '0; // see (R13) (R3)
			s_next.bitc = '0;
			s_next.st = SCMRC_IDLE;
			s_next.cas_n = 1'b1; // see (R14)
		end else if (!ce_n) begin
			unique case (s_reg.st)
			// first selected edge shows bit 0; advancing here would skip it
			SCMRC_IDLE: s_next.st = SCMRC_READ; // see (R11)
			SCMRC_READ: begin
				if (last) begin
					s_next.st = SCMRC_DONE;
					s_next.cas_n = 1'b0; // see (R1) (R2)
				end else begin
					// advance bit, then word
					s_next.bitc = SCMRC_BIT_W'(s_reg.bitc + 1'b1); // see (R11)
					if (s_reg.bitc == SCMRC_LAST_BIT)
						s_next.addr = SCMRC_ADDR_W'(s_reg.addr + 1'b1);
				end
			end
			SCMRC_DONE: s_next.cas_n = 1'b0; // see (R14)
			endcase
		end else if (s_reg.st == SCMRC_DONE) begin
			// follows chip select while not reset; counters frozen
			s_next.cas_n = 1'b1; // see (R14) (R5)
		end
		if (ce_n && s_reg.st == SCMRC_DONE && !rst_lvl) s_next.cas_n = 1'b1;
		if (!ce_n && s_reg.st == SCMRC_DONE && !rst_lvl) s_next.cas_n = 1'b0;
		// output driver: both selects low, not past the end
		s_next.doe = !ce_n && !oe_n && s_next.st != SCMRC_DONE; // see (R12) (R6) (R15) (R1)
		s_next.dout = rom[s_next.addr][s_next.bitc];
		// programming entry: supply high two edges then normal one edge
		if (s_reg.vpp_s[1] && ce_n && oe_raw) begin
			s_next.vcnt = (s_reg.vcnt == SCMRC_PGM_HIGH_EDGES) ? s_reg.vcnt
				: 2'(s_reg.vcnt + 1'b1);
			s_next.vhigh_done = 1'b0;
		end else begin
			s_next.vhigh_done = (s_reg.vcnt == SCMRC_PGM_HIGH_EDGES);
			s_next.vcnt = '0;
			if (s_reg.vhigh_done && !s_reg.vpp_s[1])
				s_next.pgm = 1'b1;
		end
		if (s_reg.pgm && !ce_n && !oe_raw) s_next.pgm = 1'b0; // see (R8)
	end
	// one state register; reset leaves the link quiet
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s_reg <= '0;
			s_reg.ce_s <= 2'h3;
			s_reg.cas_n <= 1'b1;
			s_reg.pol_hi <= 1'b1;
			s_reg.stby <= 1'b1;
			s_reg.st <= SCMRC_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end
	assign lnk.data_o = s_reg.dout;
	assign lnk.data_oe = s_reg.doe;
	assign lnk.cascade_enable_out_n = s_reg.cas_n;
	assign in_standby = s_reg.stby;
	assign pgm_mode = s_reg.pgm;
endmodule
`default_nettype wire

/* scmrc_pkg.sv */
// constants and types shared by both ends of the serial config memory link
// assumes one system clock, clk_sys at 10 MHz, on both ends
// What this block does
// (R1) after last bit: cascade low, data released
// (R2) downstream selected by low chip select
// (R3) system reset clears every chained address counter
// (R4) grounded reset pin keeps counters after configuration
// (R5) chip select high: standby, counters held
// (R6) standby keeps data released regardless of enable
// (R7) programming entry: high supply two edges, one normal
// (R8) leave programming: selects low, then power off
// (R9) polarity from first overflow word
// (R10) unprogrammed part uses active-high reset
// (R11) each selected clock after the first advances the bit counter; the address advances after the last bit
// (R12) data driven only with select and enable low
// (R13) reset level clears address and bit counters
// (R14) cascade low while enabled, follows select, then high
// (R15) data stays released past end until reset
package scmrc_pkg;
	localparam int unsigned SCMRC_WORD_BITS = 32;
	localparam int unsigned SCMRC_BIT_W = 5;
	localparam int unsigned SCMRC_ADDR_W = 11;
	// last word address of the array; the overflow word sits past this index
	localparam logic [SCMRC_ADDR_W-1:0] SCMRC_LAST_ADDR = 11'h7ff;
	localparam logic [SCMRC_BIT_W-1:0] SCMRC_LAST_BIT = 5'h1f;
	localparam logic [SCMRC_WORD_BITS-1:0] SCMRC_POL_LOW = 32'h00000000;
	// entry sequence lengths counted in clock edges
	localparam logic [1:0] SCMRC_PGM_HIGH_EDGES = 2'h2;
	localparam logic [1:0] SCMRC_PGM_NORM_EDGES = 2'h1;
	typedef enum logic [1:0] {SCMRC_IDLE, SCMRC_READ, SCMRC_DONE} scmrc_rd_e;
	typedef enum logic [1:0] {SCMRC_H_IDLE, SCMRC_H_VPP_HI, SCMRC_H_VPP_NORM,
		SCMRC_H_PROG} scmrc_host_e;
endpackage

/* scmrc_if.sv */
// pin-level link between the memory and its reader/programmer
// assumes both ends share clk_sys; the wire level of data is resolved here
`timescale 1ns/1ps
`default_nettype none
interface scmrc_if;
	logic ce_n;
	logic reset_oe;
	logic vpp_high;
	logic data_o;
	logic data_oe;
	logic cascade_enable_out_n;
	wire logic data_pin;
	// released data pin floats; pulled high as a weak resistor would
	assign data_pin = data_oe ? data_o : 1'b1;
	modport mem (input ce_n, input reset_oe, input vpp_high, input data_pin,
		output data_o, output data_oe, output cascade_enable_out_n);
	modport host (output ce_n, output reset_oe, output vpp_high,
		input data_pin, input cascade_enable_out_n);
endinterface
`default_nettype wire

/* scmrc_host.sv */
// reader end: selects the memory, collects bits, runs programming entry
// assumes the memory end drives cascade and data on the same clock
`timescale 1ns/1ps
`default_nettype none
module scmrc_host (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // synchronous reset, active low
	scmrc_if.host lnk, // pins toward the memory
	input wire logic start, // begin a read pulse
	input wire logic done_cfg, // configuration finished: reset chain unless keep_counters
	input wire logic keep_counters, // hold reset pin grounded
	input wire logic pgm_req, // run programming entry
	input wire logic pgm_exit, // leave programming
	output logic bit_valid, // high every clock while reading, until cascade out is seen low
	output logic bit_data, // received bit
	output logic chain_done, // cascade out seen low
	output logic ce_n_q, // chip select driven
	output logic reset_oe_q, // reset pin driven
	output logic vpp_q // supply high driven
);
	import scmrc_pkg::*;
	typedef struct packed {
		scmrc_host_e st;
		logic rd;
		logic [1:0] cas_s;
		logic [1:0] dat_s;
		logic [1:0] cnt;
		logic ce_n;
		logic roe;
		logic vpp;
		logic bv;
		logic bd;
		logic cd;
	} scmrc_host_s;
	scmrc_host_s s_reg, s_next;
	always_comb begin
		s_next = s_reg;
		s_next.cas_s = {s_reg.cas_s[0], lnk.cascade_enable_out_n};
		s_next.dat_s = {s_reg.dat_s[0], lnk.data_pin};
		s_next.bv = 1'b0;
		s_next.bd = s_reg.dat_s[1];
		s_next.cd = ~s_reg.cas_s[1]; // see (R2)
		unique case (s_reg.st)
		SCMRC_H_IDLE: begin
			if (start) begin
				s_next.rd = 1'b1;
				s_next.ce_n = 1'b0;
				s_next.roe = 1'b0;
			end
			if (s_reg.rd) s_next.bv = s_reg.cas_s[1];
			// finishing resets the chain unless counters are kept
			if (done_cfg) begin
				s_next.rd = 1'b0;
				s_next.roe = ~keep_counters; // see (R3) (R4)
			end
			if (pgm_req) begin
				s_next.ce_n = 1'b1;
				s_next.roe = 1'b1;
				s_next.vpp = 1'b1;
				s_next.cnt = '0;
				s_next.st = SCMRC_H_VPP_HI;
			end
		end
		SCMRC_H_VPP_HI: begin
			s_next.cnt = 2'(s_reg.cnt + 1'b1);
			if (2'(s_reg.cnt + 1'b1) == SCMRC_PGM_HIGH_EDGES) begin // see (R7)
				s_next.vpp = 1'b0;
				s_next.cnt = '0;
				s_next.st = SCMRC_H_VPP_NORM;
			end
		end
		SCMRC_H_VPP_NORM: begin
			s_next.cnt = 2'(s_reg.cnt + 1'b1);
			if (2'(s_reg.cnt + 1'b1) == SCMRC_PGM_NORM_EDGES)
				s_next.st = SCMRC_H_PROG; // see (R7)
		end
		SCMRC_H_PROG: begin
			// exit drives both selects low before power removal
			if (pgm_exit) begin
				s_next.ce_n = 1'b0;
				s_next.roe = 1'b0; // see (R8)
				s_next.st = SCMRC_H_IDLE;
			end
		end
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s_reg <= '0;
			s_reg.st <= SCMRC_H_IDLE;
			s_reg.ce_n <= 1'b1;
			s_reg.cas_s <= 2'h3;
		end else begin
			s_reg <= s_next;
		end
	end
	assign lnk.ce_n = s_reg.ce_n;
	assign lnk.reset_oe = s_reg.roe;
	assign lnk.vpp_high = s_reg.vpp;
	assign bit_valid = s_reg.bv;
	assign bit_data = s_reg.bd;
	assign chain_done = s_reg.cd;
	assign ce_n_q = s_reg.ce_n;
	assign reset_oe_q = s_reg.roe;
	assign vpp_q = s_reg.vpp;
endmodule
`default_nettype wire

/* scmrc_checker.sv */
// checker for the pins between the memory end and the reader end
// assumes the default active-high reset level on reset_oe
`timescale 1ns/1ps
`default_nettype none
module scmrc_checker (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // sync reset, active low
	input wire logic ce_n, // chip select
	input wire logic reset_oe, // reset/enable pin
	input wire logic vpp_high, // supply high
	input wire logic data_oe, // data drive enable
	input wire logic cascade_enable_out_n // chain handoff
);
	logic [17:0] bits_reg;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// bits driven since the last clear; one array at most
	always_ff @(posedge clk_sys) begin
		if (!rstn || reset_oe) begin
			bits_reg <= 18'h00000;
		end else if (data_oe) begin
			bits_reg <= bits_reg + 18'h00001;
		end
	end
	oe_gated_a: assert property (data_oe |-> !$past(ce_n, 3) && !$past(reset_oe, 3))
		else $error("data driven without select and enable");
	standby_quiet_a: assert property (ce_n [*4] |-> !data_oe)
		else $error("data driven in standby");
	cascade_quiet_a: assert property (!cascade_enable_out_n |-> !data_oe)
		else $error("data driven after handoff");
	cascade_fall_a: assert property ($fell(cascade_enable_out_n) |-> $past(data_oe))
		else $error("handoff not after last bit");
	reset_clear_a: assert property (reset_oe [*4] |-> cascade_enable_out_n)
		else $error("reset level did not clear counters");
	keep_low_a: assert property ((!cascade_enable_out_n && !ce_n && !reset_oe) [*4]
		|=> !cascade_enable_out_n)
		else $error("handoff released while enabled");
	bits_bound_a: assert property (bits_reg <= 18'h10000)
		else $error("more bits than the array holds");
	vpp_pulse_a: assert property ($rose(vpp_high) |=> vpp_high ##1 !vpp_high)
		else $error("programming supply not two edges");
endmodule
`default_nettype wire

/* tb_serial_config_memory_read_cascade.sv */
// self-checking bench: reader end and memory end joined by the link
// assumes a blank array (all ones) apart from word 0, and the default active-high reset
`timescale 1ns/1ps
`default_nettype none
module tb_serial_config_memory_read_cascade;
	import scmrc_pkg::*;
	logic clk_sys, rstn, start, done_cfg, keep_counters, pgm_req, pgm_exit;
	logic [SCMRC_WORD_BITS-1:0] pol_word;
	logic in_standby, pgm_mode, bit_valid, bit_data, chain_done;
	logic ce_n_q, reset_oe_q, vpp_q;
	int error_cnt, comparisons, cyc, n;
	// bit_data lags the pin by three clocks; this keeps the pin history
	logic [2:0] hist;
	// first word loaded by back door so the bit order is visible
	localparam logic [SCMRC_WORD_BITS-1:0] WORD0_PAT = 32'h5a3c0f96;
	logic [1:0] rows [2] = '{2'b10, 2'b01}; // keep_counters, expected cascade_enable_out_n
	scmrc_if lnk ();
	scmrc_mem scmrc_mem_inst (.clk_sys(clk_sys), .rstn(rstn), .lnk(lnk),
		.pol_word(pol_word), .in_standby(in_standby), .pgm_mode(pgm_mode));
	scmrc_host scmrc_host_inst (.clk_sys(clk_sys), .rstn(rstn), .lnk(lnk),
		.start(start), .done_cfg(done_cfg), .keep_counters(keep_counters),
		.pgm_req(pgm_req), .pgm_exit(pgm_exit), .bit_valid(bit_valid),
		.bit_data(bit_data), .chain_done(chain_done), .ce_n_q(ce_n_q),
		.reset_oe_q(reset_oe_q), .vpp_q(vpp_q));
	scmrc_checker scmrc_checker_inst (.clk_sys(clk_sys), .rstn(rstn),
		.ce_n(lnk.ce_n), .reset_oe(lnk.reset_oe), .vpp_high(lnk.vpp_high),
		.data_oe(lnk.data_oe),
		.cascade_enable_out_n(lnk.cascade_enable_out_n));
	task automatic chk(input string nm, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_cnt(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge clk_sys);
	endtask
	task automatic close_out();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// 100 ns clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// a full array read is 65536 bits, so the ceiling sits well above it
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 80000) begin
			error_cnt++;
			close_out();
		end
	end
	// inputs move only on falling edges, away from the sampling edge
	initial begin
		{rstn, start, done_cfg, keep_counters, pgm_req, pgm_exit} = '0;
		pol_word = 32'hffffffff; // blank part: active-high reset
		tick(4);
		scmrc_mem_inst.rom[0] = WORD0_PAT;
		rstn = 1'b1;
		tick(1);
		chk("in_standby", 1'b1, in_standby);
		chk("cascade", 1'b1, lnk.cascade_enable_out_n);
		chk("data_oe", 1'b0, lnk.data_oe);
		start = 1'b1;
		tick(1);
		start = 1'b0;
		n = 0;
		hist = 3'h7;
		// count driven bits until the handoff, bounded; lsb of word 0 first
		for (int i = 0; i < 70000 && lnk.cascade_enable_out_n !== 1'b0; i++) begin
			if (lnk.data_oe === 1'b1) begin
				chk("data_pin", (n < 32) ? WORD0_PAT[n] : 1'b1, lnk.data_pin);
				n++;
			end
			if (bit_valid === 1'b1) chk("bit_data", hist[2], bit_data);
			hist = {hist[1:0], lnk.data_pin};
			tick(1);
		end
		chk_cnt("bits", 32'd65536, n);
		chk("data_oe", 1'b0, lnk.data_oe);
		chk("in_standby", 1'b0, in_standby);
		tick(10);
		chk("data_oe", 1'b0, lnk.data_oe);
		chk("chain_done", 1'b1, chain_done);
		foreach (rows[r]) begin
			keep_counters = rows[r][1];
			done_cfg = 1'b1;
			tick(1);
			done_cfg = 1'b0;
			tick(8);
			chk("cascade", rows[r][0], lnk.cascade_enable_out_n);
		end
		// counters cleared, so a new selection reads from the start
		start = 1'b1;
		tick(1);
		start = 1'b0;
		tick(6);
		chk("data_oe", 1'b1, lnk.data_oe);
		rstn = 1'b0;
		tick(2);
		rstn = 1'b1;
		tick(1);
		chk("data_oe", 1'b0, lnk.data_oe);
		chk("in_standby", 1'b1, in_standby);
		pgm_req = 1'b1;
		tick(1);
		pgm_req = 1'b0;
		n = 0;
		repeat (6) begin
			if (vpp_q === 1'b1) n++;
			tick(1);
		end
		chk_cnt("vpp edges", 32'd2, n);
		tick(4);
		chk("pgm_mode", 1'b1, pgm_mode);
		pgm_exit = 1'b1;
		tick(1);
		pgm_exit = 1'b0;
		tick(4);
		chk("ce_n_q", 1'b0, ce_n_q);
		chk("reset_oe_q", 1'b0, reset_oe_q);
		chk("pgm_mode", 1'b0, pgm_mode);
		// both pins low now read the array under the default polarity
		chk("data_oe", 1'b1, lnk.data_oe);
		// an all-zero overflow word turns the low pin into a reset level
		pol_word = SCMRC_POL_LOW;
		tick(3);
		chk("data_oe", 1'b0, lnk.data_oe);
		chk("cascade", 1'b1, lnk.cascade_enable_out_n);
		close_out();
	end
endmodule
`default_nettype wire
